/* File: src/usr_consts.svh */
// constants for the universal shift register block: offsets, fields, resets
`ifndef USR_CONSTS_SVH
`define USR_CONSTS_SVH
`define USR_AXI_AW 12
`define USR_STAGES 8
`define USR_FIFO_W 8
`define USR_FIFO_D 16
`define USR_LEVEL_W 5
`define USR_OFF_CTRL 12'h000
`define USR_OFF_STAGES 12'h004
`define USR_OFF_FIFO 12'h008
`define USR_OFF_STAT 12'h00C
`define USR_CTRL_VARIANT 0
`define USR_CTRL_CAPEN 1
`define USR_CTRL_RST_CAPEN 1'b1
`define USR_FIFO_VALID 8
`define USR_STAT_FULL 5
`define USR_STAT_EMPTY 6
`define USR_STAT_OVF 7
`define USR_RESP_OKAY 2'h0
`define USR_RESP_SLVERR 2'h2
`endif

/* File: src/usr_pkg.sv */
// types shared by the universal shift register block
package usr_pkg;
   // which of the two register personalities the stages follow
   typedef enum logic {USR_VAR_BIDIR, USR_VAR_JK} usr_variant_e;
   typedef logic [7:0] usr_stage_t;
   // register decode result
   typedef enum logic [2:0] {
      REG_CTRL, REG_STAGES, REG_FIFO, REG_STAT, REG_NONE
   } usr_reg_e;
endpackage

/* File: src/usr_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module usr_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData,
   output logic [$clog2(D):0] level
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wPtr;
      logic [AW-1:0] rPtr;
      logic [AW:0] count;
   } usr_fifo_s;
   usr_fifo_s s_q;
   usr_fifo_s s_d;
   logic doPush;
   logic doPop;

   // flags come from the count register, so full and empty are exact
   assign inReady = (s_q.count != (AW+1)'(D));
   assign outValid = (s_q.count != '0);
   assign outData = s_q.mem[s_q.rPtr];
   assign level = s_q.count;
   assign doPush = inValid & inReady;
   assign doPop = outValid & outReady;

   // pointers wrap at D-1 so a depth that is not a power of two works
   always_comb begin
      s_d = s_q;
      if (doPush) begin
         s_d.mem[s_q.wPtr] = inData;
         s_d.wPtr = (s_q.wPtr == AW'(D-1)) ? '0 : s_q.wPtr + 1'b1;
      end
      if (doPop) begin
         s_d.rPtr = (s_q.rPtr == AW'(D-1)) ? '0 : s_q.rPtr + 1'b1;
      end
      s_d.count = s_q.count + (AW+1)'(doPush) - (AW+1)'(doPop);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

/* File: src/usr_shift_core.sv */
// next-state logic of the eight stages for both variants
`timescale 1ns/10ps
module usr_shift_core
   import usr_pkg::*;
(
   input wire usr_variant_e variant,
   input wire usr_stage_t stages,
   input wire logic modeSelLo,
   input wire logic modeSelHi,
   input wire logic serRight,
   input wire logic serLeft,
   input wire logic moveOrFillSel,
   input wire logic jIn,
   input wire logic kBarIn,
   input wire usr_stage_t parData,
   output usr_stage_t nextStages
);
   logic firstIn;
   logic jkFirst;

   // hold, clear, set or toggle of the first stage from the serial pair
   assign jkFirst = (jIn & ~stages[0]) | (kBarIn & stages[0]);
   assign firstIn = (variant == USR_VAR_BIDIR) ? serRight : jkFirst;

   // one mux per stage; index 0 is q_first, index 7 is q_last
   for (genvar i = 0; i < 8; i++) begin : g_stage
      logic towardLast;
      logic towardFirst;
      if (i == 0) begin : g_head
         assign towardLast = firstIn;
      end else begin : g_body
         assign towardLast = stages[i-1];
      end
      if (i == 7) begin : g_tail
         assign towardFirst = serLeft;
      end else begin : g_mid
         assign towardFirst = stages[i+1];
      end
      always_comb begin
         if (variant == USR_VAR_BIDIR) begin
            case ({modeSelHi, modeSelLo})
               2'b11: nextStages[i] = parData[i];
               2'b01: nextStages[i] = towardLast;
               2'b10: nextStages[i] = towardFirst;
               default: nextStages[i] = stages[i];
            endcase
         end else begin
            nextStages[i] = moveOrFillSel ? towardLast : parData[i];
         end
      end
   end
endmodule

/* File: src/usr_shift_top.sv */
// eight-stage universal shift register, axi4-lite status, capture fifo
//
// Operation
// - a low clear input forces all eight stages low, whatever else is set.
// - bidirectional, both mode selects high: a rise loads all 8 data bits.
// - bidir, lo select only: move toward q_last, q_first takes serRight.
// - bidir, hi select only: move toward q_first, q_last takes serLeft.
// - bidir, both mode selects low: clock rises are ignored, stages hold.
// - jk variant, moveOrFillSel high, uninhibited: a rise shifts to q_last.
// - in that shift q_first holds, clears, sets or toggles from the J/K pair.
// - the two clock inputs of the second variant are interchangeable.
// - either clock pin high blocks clocking; with one low the other clocks.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "usr_consts.svh"
module usr_shift_top
   import usr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   // shift register pins, synchronous to sys_clk
   input wire logic clearN,
   input wire logic devClkA,
   input wire logic devClkB,
   input wire logic modeSelLo,
   input wire logic modeSelHi,
   input wire logic serRight,
   input wire logic serLeft,
   input wire logic moveOrFillSel,
   input wire logic jIn,
   input wire logic kBarIn,
   input wire logic [7:0] parData,
   output logic [7:0] qStages,
   output logic captureRdy,
   // axi4-lite slave
   input wire logic [`USR_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`USR_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // state and types

   typedef struct packed {
      logic clkPrev;
      usr_stage_t stages;
      usr_variant_e variant;
      logic capEn;
      logic pushValid;
      usr_stage_t pushData;
      logic ovf;
      logic capRdy;
      logic awRdy;
      logic [`USR_AXI_AW-1:0] awAddr;
      logic wRdy;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } usr_top_s;

   // address channels come up ready, capture comes up enabled; the clock
   // history starts high because the pins rest high, so a pin that is
   // already high when reset lifts is not mistaken for a rise
   localparam usr_top_s TOP_RST = '{
      clkPrev: 1'b1,
      variant: USR_VAR_BIDIR,
      capEn: `USR_CTRL_RST_CAPEN,
      awRdy: 1'b1,
      wRdy: 1'b1,
      arRdy: 1'b1,
      default: '0
   };

   usr_top_s s_q;
   usr_top_s s_d;
   logic [1:0] rstSync_q;
   logic rstN;
   logic clkNow;
   logic devEdge;
   usr_stage_t coreNext;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoPop;
   logic [7:0] fifoOutData;
   logic [`USR_LEVEL_W-1:0] fifoLevel;
   usr_reg_e wrIdx;
   usr_reg_e rdIdx;
   logic [31:0] rdWord;

   ////////////////////////////////////////////////////////////////////////////
   // decode shared by the write and read paths

   // exact match only, so misaligned addresses fall into the unmapped case
   function automatic usr_reg_e regIndex(
      input logic [`USR_AXI_AW-1:0] addr
   );
      case (addr)
         `USR_OFF_CTRL: regIndex = REG_CTRL;
         `USR_OFF_STAGES: regIndex = REG_STAGES;
         `USR_OFF_FIFO: regIndex = REG_FIFO;
         `USR_OFF_STAT: regIndex = REG_STAT;
         default: regIndex = REG_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   // two flops so the release of arst_n never lands near a clock edge
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstN = rstSync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // stage logic and capture fifo

   // the bidirectional part has one clock pin; the other variant ors both
   // pins so either held high blocks every rise of its partner
   assign clkNow = (s_q.variant == USR_VAR_BIDIR) ?
                   devClkA : (devClkA | devClkB);
   // a rise is a low sample followed by a high one; a level never counts
   assign devEdge = clkNow & ~s_q.clkPrev;

   usr_shift_core u_core (
      .variant(s_q.variant),
      .stages(s_q.stages),
      .modeSelLo(modeSelLo),
      .modeSelHi(modeSelHi),
      .serRight(serRight),
      .serLeft(serLeft),
      .moveOrFillSel(moveOrFillSel),
      .jIn(jIn),
      .kBarIn(kBarIn),
      .parData(parData),
      .nextStages(coreNext)
   );

   // every stage change made by a clock rise is queued for software
   // limitation: only seventeen rises are buffered, sixteen in the fifo and one in the holding slot; a slow reader loses the
   // middle of a burst and finds the overflow flag set
   usr_fifo #(
      .W(`USR_FIFO_W),
      .D(`USR_FIFO_D)
   ) u_fifo (
      .clk(sys_clk),
      .rstN(rstN),
      .inValid(s_q.pushValid),
      .inReady(fifoInReady),
      .inData(s_q.pushData),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData),
      .level(fifoLevel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register decode and read word

   assign wrIdx = regIndex(s_q.awAddr);
   assign rdIdx = regIndex(s_axi_araddr);
   // a read of the data word pops the fifo in the cycle the address is taken
   // the pop and the sampled head share one edge, so a read never skips or
   // repeats a word even when a capture lands in the same cycle
   assign fifoPop = s_axi_arvalid & s_q.arRdy & (rdIdx == REG_FIFO);

   // unmapped and reserved bits read as zero
   // status bits are live, so software sees the fifo as it is at the take
   always_comb begin
      rdWord = 32'h0000_0000;
      case (rdIdx)
         REG_CTRL: begin
            rdWord[`USR_CTRL_VARIANT] = (s_q.variant == USR_VAR_JK);
            rdWord[`USR_CTRL_CAPEN] = s_q.capEn;
         end
         REG_STAGES: begin
            rdWord[7:0] = s_q.stages;
         end
         REG_FIFO: begin
            rdWord[7:0] = fifoOutValid ? fifoOutData : 8'h00;
            rdWord[`USR_FIFO_VALID] = fifoOutValid;
         end
         REG_STAT: begin
            rdWord[`USR_LEVEL_W-1:0] = fifoLevel;
            rdWord[`USR_STAT_FULL] = ~fifoInReady;
            rdWord[`USR_STAT_EMPTY] = ~fifoOutValid;
            rdWord[`USR_STAT_OVF] = s_q.ovf;
         end
         default: begin
            rdWord = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      s_d.clkPrev = clkNow;
      s_d.capRdy = fifoInReady;

      // an accepted capture frees the holding slot
      if (s_q.pushValid && fifoInReady) begin
         s_d.pushValid = 1'b0;
      end

      // clear overrides everything, including a coincident clock rise
      if (!clearN) begin
         s_d.stages = 8'h00;
      end else if (devEdge) begin
         // mode pins are taken at the rise; the driver keeps them steady
         // around it, so sampling here sees settled levels
         s_d.stages = coreNext;
         if (s_q.capEn) begin
            // a slot still waiting on a full fifo is overwritten: newest wins
            if (s_q.pushValid && !fifoInReady) begin
               s_d.ovf = 1'b1;
            end
            s_d.pushValid = 1'b1;
            s_d.pushData = coreNext;
         end
      end

      // write address and data are taken independently, in either order
      // one write at a time: both stay closed until the response is taken
      if (s_axi_awvalid && s_q.awRdy) begin
         s_d.awRdy = 1'b0;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wRdy) begin
         s_d.wRdy = 1'b0;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end

      // both halves held and no response outstanding: perform the write
      if (!s_q.awRdy && !s_q.wRdy && !s_q.bValid) begin
         s_d.bValid = 1'b1;
         s_d.bResp = `USR_RESP_OKAY;
         case (wrIdx)
            REG_CTRL: begin
               if (s_q.wStrb[0]) begin
                  s_d.variant = usr_variant_e'(s_q.wData[`USR_CTRL_VARIANT]);
                  s_d.capEn = s_q.wData[`USR_CTRL_CAPEN];
               end
            end
            REG_STAT: begin
               // writing one clears; an overflow in the same cycle survives
               // the clear goes first and the set path is weighed after it
               if (s_q.wStrb[0] && s_q.wData[`USR_STAT_OVF]) begin
                  s_d.ovf = 1'b0;
                  if (!clearN || !devEdge || !s_q.capEn) begin
                     s_d.ovf = 1'b0;
                  end else if (s_q.pushValid && !fifoInReady) begin
                     s_d.ovf = 1'b1;
                  end
               end
            end
            REG_STAGES, REG_FIFO: begin
               // read-only words accept and ignore the write
               s_d.bResp = `USR_RESP_OKAY;
            end
            default: begin
               s_d.bResp = `USR_RESP_SLVERR;
            end
         endcase
      end

      // response taken: reopen both write channels
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
         s_d.awRdy = 1'b1;
         s_d.wRdy = 1'b1;
      end

      // read: answer one cycle after the address is taken
      // the word is latched at the take so a later pop cannot alter it
      if (s_axi_arvalid && s_q.arRdy) begin
         s_d.arRdy = 1'b0;
         s_d.rValid = 1'b1;
         s_d.rData = rdWord;
         s_d.rResp = (rdIdx == REG_NONE) ?
                     `USR_RESP_SLVERR : `USR_RESP_OKAY;
      end
      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
         s_d.arRdy = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   // the synchronised reset keeps the struct and the fifo in step
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         s_q <= TOP_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign qStages = s_q.stages;
   assign captureRdy = s_q.capRdy;
   assign s_axi_awready = s_q.awRdy;
   assign s_axi_wready = s_q.wRdy;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_arready = s_q.arRdy;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
endmodule

/* File: tb/usr_shift_monitor.sv */
// concurrent checks on the shift register pins of the top module
`timescale 1ns/10ps
`include "usr_consts.svh"
module usr_shift_monitor (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clearN,
   input wire logic devClkA,
   input wire logic devClkB,
   input wire logic modeSelLo,
   input wire logic modeSelHi,
   input wire logic serRight,
   input wire logic serLeft,
   input wire logic moveOrFillSel,
   input wire logic jIn,
   input wire logic kBarIn,
   input wire logic [7:0] parData,
   input wire logic [7:0] qStages,
   input wire logic [`USR_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready
);
   logic jkQ, prevA, prevB, bRise, jRise, wTake;
   ////////////////////////////////////////////////////////////////////////
   // variant shadow leads the design by one cycle; no rise falls in there
   assign wTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         jkQ <= 1'b0;
         prevA <= 1'b1;
         prevB <= 1'b1;
      end else begin
         prevA <= devClkA;
         prevB <= devClkB;
         if (wTake && s_axi_wready && s_axi_awaddr == `USR_OFF_CTRL
             && s_axi_wstrb[0]) begin
            jkQ <= s_axi_wdata[`USR_CTRL_VARIANT];
         end
      end
   end
   // a clock rise as the design samples it; bidir ignores pin b
   assign bRise = clearN && !jkQ && devClkA && !prevA;
   assign jRise = clearN && jkQ && (devClkA || devClkB) && !(prevA || prevB);
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   clear_zero_a: assert property (
      !clearN |=> qStages == 8'h00)
      else $error("stages not cleared");
   steady_hold_a: assert property (
      clearN && !bRise && !jRise |=> $stable(qStages))
      else $error("stages moved without a clock rise");
   par_load_a: assert property (
      bRise && modeSelLo && modeSelHi |=> qStages == $past(parData))
      else $error("parallel load wrong");
   right_shift_a: assert property (
      bRise && modeSelLo && !modeSelHi |=>
      qStages == {$past(qStages[6:0]), $past(serRight)})
      else $error("right shift wrong");
   left_shift_a: assert property (
      bRise && !modeSelLo && modeSelHi |=>
      qStages == {$past(serLeft), $past(qStages[7:1])})
      else $error("left shift wrong");
   mode_idle_a: assert property (
      bRise && !modeSelLo && !modeSelHi |=> $stable(qStages))
      else $error("idle mode changed stages");
   jk_shift_a: assert property (
      jRise && moveOrFillSel |=> qStages[7:1] == $past(qStages[6:0]))
      else $error("serial shift wrong");
   jk_serial_a: assert property (
      jRise && moveOrFillSel |=> qStages[0] ==
      (($past(jIn) && !$past(qStages[0])) ||
       ($past(kBarIn) && $past(qStages[0]))))
      else $error("first stage entry wrong");
   jk_load_a: assert property (
      jRise && !moveOrFillSel |=> qStages == $past(parData))
      else $error("serial variant load wrong");
   clk_inhibit_a: assert property (
      jkQ && clearN && ((devClkA && prevA) || (devClkB && prevB))
      |=> $stable(qStages))
      else $error("inhibited clock moved stages");
   cover property (bRise && modeSelLo && modeSelHi);
   cover property (jRise && moveOrFillSel);
   cover property (!clearN && jkQ && devClkB && !prevB);
endmodule
bind usr_shift_top usr_shift_monitor i_mon (
   .sys_clk(sys_clk), .arst_n(arst_n), .clearN(clearN),
   .devClkA(devClkA), .devClkB(devClkB), .modeSelLo(modeSelLo),
   .modeSelHi(modeSelHi), .serRight(serRight), .serLeft(serLeft),
   .moveOrFillSel(moveOrFillSel), .jIn(jIn), .kBarIn(kBarIn),
   .parData(parData), .qStages(qStages), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready)
);

/* File: tb/usr_pin_partner.sv */
// model of the surrounding logic that pulses the device clock pins
`timescale 1ns/10ps
module usr_pin_partner (
   input wire logic sys_clk,
   input wire logic req,
   input wire logic useB,
   input wire logic inhibit,
   output logic devClkA,
   output logic devClkB,
   output logic done
);
   logic [1:0] st = 2'h0;
   logic clkLvl = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   // one low cycle then high; resting high lets modes move safely
   always @(posedge sys_clk) begin
      if (st == 2'h1) clkLvl <= 1'b0;
      if (st == 2'h2) clkLvl <= 1'b1;
      done <= (st == 2'h2);
      st <= (st == 2'h0) ? {1'b0, req} : st + 2'h1;
   end
   // the idle pin acts as inhibit, raised only while clkLvl is high
   assign devClkA = useB ? inhibit : clkLvl;
   assign devClkB = useB ? clkLvl : inhibit;
endmodule

/* File: tb/usr_shift_top_test.sv */
// self-checking bench of the universal shift register top
`timescale 1ns/10ps
`include "usr_consts.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
module usr_shift_top_test;
   logic sys_clk = 0, arst_n = 0, clearN = 1, modeSelLo = 0, modeSelHi = 0;
   logic serRight = 0, serLeft = 0, moveOrFillSel = 0, jIn = 0, kBarIn = 0;
   logic req = 0, useB = 0, inhibit = 0, jk = 0, pDone, captureRdy;
   logic devClkA, devClkB, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] parData = 0, qStages, expQ = 0;
   logic [7:0] cap[$];
   int n_errors = 0, n_tests = 0, cyc = 0, seed = 8452, v, k;
   always #25 sys_clk = ~sys_clk;
   usr_shift_top i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clearN(clearN),
      .devClkA(devClkA), .devClkB(devClkB), .modeSelLo(modeSelLo),
      .modeSelHi(modeSelHi), .serRight(serRight), .serLeft(serLeft),
      .moveOrFillSel(moveOrFillSel), .jIn(jIn), .kBarIn(kBarIn),
      .parData(parData), .qStages(qStages), .captureRdy(captureRdy),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   usr_pin_partner i_part (.sys_clk(sys_clk), .req(req), .useB(useB),
      .inhibit(inhibit), .devClkA(devClkA), .devClkB(devClkB), .done(pDone));
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // a hang anywhere counts as a mismatch
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         wrap_up();
      end
   end
   // address and data offered together; bready is raised with them and held for the answer
   task automatic axWr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic axRd(input logic [11:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // one device clock pulse; stages settle after the edge done is seen
   task automatic pulse();
      @(posedge sys_clk);
      req <= 1'b1;
      @(posedge sys_clk);
      req <= 1'b0;
      while (pDone !== 1'b1) @(posedge sys_clk);
      #1;
   endtask
   task automatic step();
      if (!jk) begin
         case ({modeSelHi, modeSelLo})
            2'h3: expQ = parData;
            2'h1: expQ = {expQ[6:0], serRight};
            2'h2: expQ = {serLeft, expQ[7:1]};
            default: ;
         endcase
      end else if (moveOrFillSel) begin
         expQ = {expQ[6:0], (jIn & ~expQ[0]) | (kBarIn & expQ[0])};
      end else expQ = parData;
   endtask
   task automatic inhibitCheck();
      @(posedge sys_clk);
      inhibit <= 1'b1;
      pulse();
      `CHK("inhibit", expQ, qStages)
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("stage reset", 8'h00, qStages)
      `CHK("ready reset", 1'b1, captureRdy)
      axRd(`USR_OFF_CTRL);
      `CHK("ctrl reset", 32'h0000_0002, rd)
      axRd(`USR_OFF_STAT);
      `CHK("stat reset", 32'h0000_0040, rd)
      axRd(12'h010);
      `CHK("unmapped rresp", `USR_RESP_SLVERR, rs)
      `CHK("unmapped rdata", 32'h0000_0000, rd)
      axWr(12'h010, 32'hFFFF_FFFF);
      `CHK("unmapped bresp", `USR_RESP_SLVERR, rs)
      axWr(`USR_OFF_STAGES, 32'h0000_00FF);
      `CHK("ro bresp", `USR_RESP_OKAY, rs)
      axWr(`USR_OFF_CTRL, 32'h0000_0000);
      pulse();
      `CHK("idle start", 8'h00, qStages)
      $display("test reset and registers done");
      for (k = 0; k < 90; k++) begin
         if (k == 40) begin
            axWr(`USR_OFF_CTRL, 32'h0000_0001);
            jk = 1'b1;
         end
         if (k == 65) begin
            inhibitCheck();
            @(posedge sys_clk);
            useB <= 1'b1;
            @(posedge sys_clk);
            inhibit <= 1'b0;
         end
         @(posedge sys_clk);
         v = $random(seed);
         modeSelLo <= v[0];
         modeSelHi <= v[1];
         serRight <= v[2];
         serLeft <= v[3];
         moveOrFillSel <= v[4] | v[5];
         jIn <= v[6];
         kBarIn <= v[7];
         parData <= v[15:8];
         pulse();
         step();
         `CHK("stages", expQ, qStages)
         axRd(`USR_OFF_STAGES);
         `CHK("stage reg", {24'h00_0000, expQ}, rd)
      end
      inhibitCheck();
      @(posedge sys_clk);
      inhibit <= 1'b0;
      $display("test shift modes done");
      clearN <= 1'b0;
      moveOrFillSel <= 1'b0;
      pulse();
      expQ = 8'h00;
      `CHK("clear", expQ, qStages)
      axWr(`USR_OFF_CTRL, 32'h0000_0003);
      clearN <= 1'b1;
      for (k = 0; k < 18; k++) begin
         @(posedge sys_clk);
         parData <= 8'hA0 + k[7:0];
         pulse();
         cap.push_back(8'hA0 + k[7:0]);
      end
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("fifo full ready", 1'b0, captureRdy)
      axRd(`USR_OFF_STAT);
      `CHK("stat full", 32'h0000_00B0, rd)
      axWr(`USR_OFF_STAT, 32'h0000_0080);
      axRd(`USR_OFF_STAT);
      `CHK("stat ovf clear", 32'h0000_0030, rd)
      cap.delete(16);
      for (k = 0; k < 17; k++) begin
         axRd(`USR_OFF_FIFO);
         `CHK("fifo word", {24'h00_0001, cap[k]}, rd)
      end
      axRd(`USR_OFF_FIFO);
      `CHK("fifo empty", 1'b0, rd[`USR_FIFO_VALID])
      axRd(`USR_OFF_STAT);
      `CHK("stat drained", 32'h0000_0040, rd)
      $display("test clear and capture done");
      wrap_up();
   end
endmodule
